//--- common/vlm_cfg.svh
`ifndef VLM_CFG_SVH
`define VLM_CFG_SVH

// Detection switch codes
`define VLM_SW_OFF        2'h0
`define VLM_SW_WARN       2'h1
`define VLM_SW_ALARM      2'h2

// Sensitivity limits and reset value, percent
`define VLM_SENS_MIN      10'h032
`define VLM_SENS_MAX      10'h1f4
`define VLM_SENS_RST      10'h064
`define VLM_PCT_DIV       10'h064

// Detection level reset value, mm/s
`define VLM_LEVEL_RST     16'h0032

// Write-protect permitted code
`define VLM_WP_PERMIT     4'h0

// Completion indication time
`define VLM_DONE_MS       1000
`define VLM_CLK_KHZ       125000
`define VLM_DONE_CYCLES   (`VLM_DONE_MS * `VLM_CLK_KHZ)

`endif

//--- common/vlm_pkg.sv
package vlm_pkg;

  typedef enum {
    VLM_IDLE,
    VLM_LEARN,
    VLM_DONE
  } vlm_state_t;

  typedef struct packed {
    logic [1:0]  detect_switch;
    logic [9:0]  sensitivity_pct;
    logic [3:0]  write_protect;
    logic        motorless_test;
  } vlm_cfg_t;

  typedef struct packed {
    logic warning;
    logic alarm;
    logic over;
  } vlm_status_t;

endpackage : vlm_pkg

//--- test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import vlm_pkg::*;
  localparam int unsigned DC = 20;
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  vlm_cfg_t    cfg;
  logic        level_wr, start_key, speed_valid;
  logic        warn, alarm, act, done, refd, blk;
  logic [15:0] level_wdata, amp, speed, level, mag;
  logic [9:0]  sens;
  logic [9:0]  sv [5] = '{10'h014, 10'h032, 10'h1f4, 10'h1f5, 10'h0c8};
  logic [9:0]  se [5] = '{10'h032, 10'h032, 10'h1f4, 10'h1f4, 10'h0c8};
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          nw, na, nr, nd;
  always #4 ref_clk = ~ref_clk;
  vlm_panel u_vlm_panel (.ref_clk(ref_clk), .amp(amp), .speed(speed),
    .speed_valid(speed_valid));
  vlm_monitor #(.SPEED_W(16), .DONE_CYCLES(DC)) u_vlm_monitor (
    .ref_clk(ref_clk), .resetn(resetn), .speed(speed),
    .speed_valid(speed_valid), .cfg(cfg), .level_wr(level_wr),
    .level_wdata(level_wdata), .start_key(start_key),
    .vib_detect_level(level), .vib_sensitivity_pct(sens), .vib_mag(mag),
    .vib_warning(warn), .vib_alarm(alarm), .init_active(act),
    .init_done(done), .init_refused(refd), .level_wr_blocked(blk));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic final_report;
    $display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic run(input int n);
    repeat (n) begin
      @(negedge ref_clk);
      nw += int'(warn === 1'b1);
      na += int'(alarm === 1'b1);
      nr += int'(refd === 1'b1);
      nd += int'(done === 1'b1);
    end
  endtask : run
  task automatic clr;
    {nw, na, nr, nd} = '0;
  endtask : clr
  task automatic press;
    start_key = 1'b1;
    run(1);
    start_key = 1'b0;
    run(5);
  endtask : press
  task automatic wr(input logic [15:0] d);
    level_wdata = d;
    level_wr = 1'b1;
    @(negedge ref_clk);
    level_wr = 1'b0;
    @(negedge ref_clk);
  endtask : wr
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_mismatch++;
    final_report;
  end
  initial begin
    cfg = '{2'h0, 10'h064, 4'h0, 1'b0};
    {level_wr, start_key, level_wdata, amp} = '0;
    repeat (20) @(negedge ref_clk);
    resetn = 1'b1;
    chk(level, 16'h0032);
    chk(16'(sens), 16'h0064);
    run(400);
    amp = 16'h0400;
    for (int s = 0; s < 3; s++) begin
      cfg.detect_switch = 2'(s);
      run(4);
      clr;
      run(100);
      chk(16'(nw != 0), 16'(s == 1));
      chk(16'(na != 0), 16'(s == 2));
    end
    amp = 16'h0000;
    cfg.detect_switch = 2'h1;
    run(400);
    clr;
    run(100);
    chk(16'(nw), 16'h0);
    chk(mag, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      cfg.sensitivity_pct = sv[i];
      @(negedge ref_clk);
      chk(16'(sens), 16'(se[i]));
    end
    wr(16'h00aa);
    chk(level, 16'h00aa);
    cfg.write_protect = 4'h1;
    clr;
    press;
    chk(16'(nr), 16'h1);
    chk(16'(act), 16'h0);
    cfg = '{2'h1, 10'h0c8, 4'h0, 1'b1};
    clr;
    press;
    chk(16'(nr), 16'h1);
    chk(16'(act), 16'h0);
    cfg.motorless_test = 1'b0;
    amp = 16'h0400;
    press;
    chk(16'(act), 16'h1);
    wr(16'h0011);
    chk(level, 16'h00aa);
    chk(16'(blk), 16'h1);
    cfg.sensitivity_pct = 10'h12c;
    run(60);
    chk(16'(sens), 16'h012c);
    chk(16'(act), 16'h1);
    clr;
    press;
    chk(level, 16'h00aa);
    chk(16'(act), 16'h0);
    run(40);
    chk(16'(nd >= DC && nd <= DC + 1), 16'h1);
    chk(16'(level > 16'h0200), 16'h1);
    chk(16'(blk), 16'h0);
    chk(16'(sens), 16'h012c);
    final_report;
  end
endmodule : testbench
`default_nettype wire

//--- test/vlm_chk_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module vlm_chk
  import vlm_pkg::*;
#(parameter int unsigned DONE_CYCLES = 20) (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        resetn,
  // Inputs
  input wire vlm_cfg_t    cfg,
  input wire logic        level_wr,
  input wire logic        start_key,
  // Status
  input wire logic [15:0] vib_detect_level,
  input wire logic [9:0]  vib_sensitivity_pct,
  input wire logic [15:0] vib_mag,
  input wire logic        vib_warning,
  input wire logic        vib_alarm,
  input wire logic        init_active,
  input wire logic        init_done,
  input wire logic        init_refused,
  input wire logic        level_wr_blocked
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic [31:0] done_cnt;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn)        done_cnt <= 32'h0;
    else if (init_done) done_cnt <= done_cnt + 32'h1;
    else                done_cnt <= 32'h0;
  end
  sequence s_press;
    $rose(start_key) && !init_active && !init_done;
  endsequence
  sequence s_bad;
    s_press ##0 (cfg.write_protect != 4'h0 || cfg.motorless_test);
  endsequence
  AST_WARN_SW: assert property (vib_warning |->
    $past(cfg.detect_switch) == 2'h1 || $past(cfg.detect_switch, 2) == 2'h1)
    else $error("warning outside switch one");
  AST_ALARM_SW: assert property (vib_alarm |->
    $past(cfg.detect_switch) == 2'h2 || $past(cfg.detect_switch, 2) == 2'h2)
    else $error("alarm outside switch two");
  AST_OVER: assert property (vib_warning || vib_alarm |->
    32'(vib_mag) * 32'h64 >
    32'($past(vib_detect_level)) * 32'($past(vib_sensitivity_pct)))
    else $error("flag without threshold excess");
  AST_SENS: assert property (cfg.sensitivity_pct inside
    {[10'h032:10'h1f4]} |=> vib_sensitivity_pct == $past(cfg.sensitivity_pct))
    else $error("sensitivity not taken");
  AST_REFUSE: assert property (s_bad |-> ##[1:2] init_refused)
    else $error("refusal missing");
  AST_NOSTART: assert property (s_bad |=> !init_active [*3])
    else $error("refused press started learning");
  AST_START: assert property (s_press ##0 (cfg.write_protect == 4'h0
    && !cfg.motorless_test) |-> ##2 init_active)
    else $error("learning not started");
  AST_BLOCK: assert property ((init_active || init_done) ==
    $past(level_wr_blocked)) else $error("level not blocked");
  AST_HOLD: assert property (init_active && level_wr |=>
    $stable(vib_detect_level)) else $error("level written in learning");
  AST_DONE: assert property ($fell(init_done) |-> done_cnt >=
    DONE_CYCLES && done_cnt <= DONE_CYCLES + 1) else $error("done length");
  COV_WARN: cover property (vib_warning);
  COV_ALARM: cover property (vib_alarm);
  COV_REF: cover property (init_refused);
  COV_DONE: cover property ($fell(init_done));
endmodule : vlm_chk
bind vlm_monitor vlm_chk #(.DONE_CYCLES(DONE_CYCLES)) u_chk (
  .ref_clk(ref_clk), .resetn(resetn), .cfg(cfg), .level_wr(level_wr),
  .start_key(start_key), .vib_detect_level(vib_detect_level),
  .vib_sensitivity_pct(vib_sensitivity_pct), .vib_mag(vib_mag),
  .vib_warning(vib_warning), .vib_alarm(vib_alarm),
  .init_active(init_active), .init_done(init_done),
  .init_refused(init_refused), .level_wr_blocked(level_wr_blocked));
`default_nettype wire

//--- test/vlm_panel.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Motor speed source with square vibration
// ----------------------------------------
module vlm_panel (
  // Clock
  input  wire logic        ref_clk,
  // Vibration amplitude
  input  wire logic [15:0] amp,
  // Speed samples
  output logic      [15:0] speed,
  output logic             speed_valid
);
  logic [3:0] ph = 4'h0;
  always @(negedge ref_clk) begin
    ph <= ph + 4'h1;
    speed_valid <= 1'b1;
    speed <= ph[3] ? 16'h4000 + amp : 16'h4000 - amp;
  end
endmodule : vlm_panel
`default_nettype wire

//--- verilog/vlm_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "vlm_cfg.svh"

// How it works
// - Switch at zero means no detection, no warning and no alarm.
// - Switch at one raises the warning when vibration tops the threshold.
// - Switch at two raises the alarm instead of the warning.
// - Threshold is level times sensitivity over 100, compared strictly.
// - Vibration is derived from the motor speed signal.
// - Sensitivity is clamped to 50..500, resets to 100, acts at once.
// - Learning starts only when write protect is at permitted.
// - Learning starts only when motorless test select is zero.
// - Learning runs from one start key press until the next one.
// - Second press shows done for one second, then the level loads.
// - Level writes are blocked while learning and while done shows; sensitivity stays open.
module vlm_monitor
  import vlm_pkg::*;
#(
  parameter int          SPEED_W     = 16,
  parameter int unsigned DONE_CYCLES = `VLM_DONE_CYCLES
) (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               resetn,
  // Motor speed
  input  wire logic [SPEED_W-1:0] speed,
  input  wire logic               speed_valid,
  // Parameter settings
  input  wire vlm_cfg_t           cfg,
  input  wire logic               level_wr,
  input  wire logic [15:0]        level_wdata,
  // Operator key
  input  wire logic               start_key,
  // Status
  output logic [15:0]             vib_detect_level,
  output logic [9:0]              vib_sensitivity_pct,
  output logic [15:0]             vib_mag,
  output logic                    vib_warning,
  output logic                    vib_alarm,
  output logic                    init_active,
  output logic                    init_done,
  output logic                    init_refused,
  output logic                    level_wr_blocked
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [9:0] clamp_sens(input logic [9:0] v);
    if (v < `VLM_SENS_MIN) begin
      return `VLM_SENS_MIN;
    end else if (v > `VLM_SENS_MAX) begin
      return `VLM_SENS_MAX;
    end
    return v;
  endfunction : clamp_sens

  function automatic logic [19:0] calc_thresh(input logic [15:0] lvl,
                                              input logic [9:0]  pct);
    logic [25:0] prod;
    prod = lvl * pct;
    return 20'(prod / 26'(`VLM_PCT_DIV));
  endfunction : calc_thresh

  // ----------------------------------------------------------------
  // Vibration measurement
  // ----------------------------------------------------------------
  logic [15:0] mag;
  logic        mag_valid;

  vlm_vib_meter #(
    .SPEED_W (SPEED_W),
    .SHIFT   (4)
  ) u_meter (
    .ref_clk     (ref_clk),
    .resetn      (resetn),
    .speed       (speed),
    .speed_valid (speed_valid),
    .vib_mag     (mag),
    .vib_valid   (mag_valid)
  );

  // ----------------------------------------------------------------
  // Sensitivity
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      vib_sensitivity_pct <= `VLM_SENS_RST;
    end else begin
      vib_sensitivity_pct <= clamp_sens(cfg.sensitivity_pct);
    end
  end

  // ----------------------------------------------------------------
  // Learning sequence
  // ----------------------------------------------------------------
  vlm_state_t  state_reg;
  logic [31:0] done_cnt_reg;
  logic [15:0] peak_reg;
  logic        key_prev_reg;
  logic        key_press;
  logic        start_ok;

  assign key_press = start_key & ~key_prev_reg;
  assign start_ok  = (cfg.write_protect == `VLM_WP_PERMIT) &&
                     !cfg.motorless_test;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      key_prev_reg <= 1'b0;
    end else begin
      key_prev_reg <= start_key;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= VLM_IDLE;
    end else begin
      unique case (state_reg)
        VLM_IDLE: begin
          if (key_press && start_ok) begin
            state_reg <= VLM_LEARN;
          end
        end
        VLM_LEARN: begin
          if (key_press) begin
            state_reg <= VLM_DONE;
          end
        end
        VLM_DONE: begin
          if (done_cnt_reg == DONE_CYCLES - 1) begin
            state_reg <= VLM_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Completion timer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      done_cnt_reg <= '0;
    end else if (state_reg != VLM_DONE) begin
      done_cnt_reg <= '0;
    end else if (done_cnt_reg != DONE_CYCLES - 1) begin
      done_cnt_reg <= done_cnt_reg + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Refused start press
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      init_refused <= 1'b0;
    end else begin
      init_refused <= (state_reg == VLM_IDLE) && key_press &&
                      !start_ok;
    end
  end

  // Peak capture while learning
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      peak_reg <= 16'h0000;
    end else if (state_reg == VLM_IDLE && key_press && start_ok) begin
      peak_reg <= 16'h0000;
    end else if (state_reg == VLM_LEARN && mag_valid && mag > peak_reg) begin
      peak_reg <= mag;
    end
  end

  // ----------------------------------------------------------------
  // Detection level
  // ----------------------------------------------------------------
  logic load_learned;

  assign load_learned = (state_reg == VLM_DONE) &&
                        (done_cnt_reg == DONE_CYCLES - 1);
  assign level_wr_blocked = (state_reg != VLM_IDLE);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      vib_detect_level <= `VLM_LEVEL_RST;
    end else if (load_learned) begin
      vib_detect_level <= peak_reg;
    end else if (level_wr && !level_wr_blocked) begin
      vib_detect_level <= level_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Detection and outputs
  // ----------------------------------------------------------------
  logic [19:0] thresh;
  logic        over;

  assign thresh = calc_thresh(vib_detect_level, vib_sensitivity_pct);
  assign over   = mag_valid && ({4'h0, mag} > thresh);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      vib_warning <= 1'b0;
      vib_alarm   <= 1'b0;
    end else begin
      unique case (cfg.detect_switch)
        `VLM_SW_WARN: begin
          vib_warning <= over;
          vib_alarm   <= 1'b0;
        end
        `VLM_SW_ALARM: begin
          vib_warning <= 1'b0;
          vib_alarm   <= over;
        end
        default: begin
          vib_warning <= 1'b0;
          vib_alarm   <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      vib_mag <= 16'h0000;
    end else if (mag_valid) begin
      vib_mag <= mag;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      init_active <= 1'b0;
    end else begin
      init_active <= (state_reg == VLM_LEARN);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      init_done <= 1'b0;
    end else begin
      init_done <= (state_reg == VLM_DONE);
    end
  end

endmodule : vlm_monitor

`default_nettype wire

//--- verilog/vlm_vib_meter.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Vibration magnitude from motor speed
// ----------------------------------------------------------------
module vlm_vib_meter #(
  parameter int SPEED_W = 16,
  parameter int SHIFT   = 4
) (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               resetn,
  // Speed sample
  input  wire logic [SPEED_W-1:0] speed,
  input  wire logic               speed_valid,
  // Vibration magnitude, mm/s
  output logic      [15:0]        vib_mag,
  output logic                    vib_valid
);

  logic signed [SPEED_W+SHIFT:0] avg_reg;
  logic signed [SPEED_W:0]       diff;
  logic signed [SPEED_W:0]       speed_s;

  assign speed_s = {1'b0, speed};
  assign diff    = speed_s - (SPEED_W+1)'(avg_reg >>> SHIFT);

  // Low-pass of speed; deviation from it is the vibration part
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      avg_reg <= '0;
    end else if (speed_valid) begin
      avg_reg <= avg_reg + (SPEED_W+SHIFT+1)'(diff);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      vib_mag   <= 16'h0000;
      vib_valid <= 1'b0;
    end else begin
      vib_valid <= speed_valid;
      if (speed_valid) begin
        vib_mag <= 16'((diff < 0) ? -diff : diff);
      end
    end
  end

endmodule : vlm_vib_meter

`default_nettype wire
